// >>> hw/wit_pkg.sv
// wit_pkg: constants for the watchdog / interval timer
// assumes a cpu bus on the same clock as the timer
package wit_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [15:0] WIT_CSR_ADDR   = 16'hffaa;
	localparam logic [15:0] WIT_CNT_ADDR   = 16'hffab;
	localparam logic [7:0]  WIT_PW_CNT     = 8'h5a;
	localparam logic [7:0]  WIT_PW_CSR     = 8'ha5;
	localparam logic [7:0]  WIT_CSR_RESET  = 8'h10;
	localparam logic [7:0]  WIT_CNT_RESET  = 8'h00;
	localparam logic [7:0]  WIT_CNT_MAX    = 8'hff;
	// ---------------------------------------------------------------
	// control/status field positions
	// ---------------------------------------------------------------
	localparam int          WIT_OVF_BIT    = 7;
	localparam int          WIT_MODE_BIT   = 6;
	localparam int          WIT_RUN_BIT    = 5;
	localparam int          WIT_ONE_BIT    = 4;
	localparam int          WIT_ACT_BIT    = 3;
	localparam int          WIT_CKS_MSB    = 2;
	localparam int          WIT_CKS_W      = 3;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int          WIT_PRE_W      = 12;
	localparam int          WIT_RST_HOLD   = 518;
	localparam int          WIT_HOLD_W     = 10;
	localparam logic [WIT_HOLD_W-1:0] WIT_RST_HOLD_CNT = WIT_HOLD_W'(WIT_RST_HOLD);
	// divisor - 1 for each clock-select code, ascending
	localparam logic [WIT_PRE_W-1:0] WIT_DIV_MASK [8] = '{
		12'h001, 12'h01f, 12'h03f, 12'h07f,
		12'h0ff, 12'h1ff, 12'h7ff, 12'hfff};
endpackage

// >>> hw/wit_prescaler.sv
// wit_prescaler: free-running divider giving one tick per selected period
// assumes a synchronous active-low reset copy from the top
`timescale 1ns/1ps
module wit_prescaler (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic [wit_pkg::WIT_CKS_W-1:0]  sel,
	output logic                                tick
);
	import wit_pkg::*;

	logic [WIT_PRE_W-1:0] div_r;

	// ---------------------------------------------------------------
	// divider
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// one pulse per selected period; a select change mid-count may shorten one period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else begin
			tick <= ((div_r & WIT_DIV_MASK[sel]) == WIT_DIV_MASK[sel]);  // see RULE11
		end
	end
endmodule

// >>> hw/wit_top.sv
// wit_top: 8-bit watchdog / interval timer with password-protected writes
// assumes cpu bus strobes on MCLK; chip reset logic consumes CHIP_RST
//
// Functional notes
// RULE1: 8-bit up-counter, counts ticks while running
// RULE2: wrap from max to zero sets overflow
// RULE3: counter zero at reset or when stopped
// RULE4: standby clears bits 7-5, 3; keeps select
// RULE5: overflow cleared by read-then-write-zero only; standby also clears it here
// RULE6: bit 6 selects interval or watchdog mode
// RULE7: bit 5 runs counter, enables overflow requests
// RULE8: bit 4 always reads one
// RULE9: bit 3 picks reset, else nmi
// RULE10: bits 2-0 pick one of eight clocks
// RULE11: codes map to /2 up to /4096
// RULE12: word writes with 5a or a5 password
// RULE13: watchdog reset holds chip 518 cycles
// RULE14: interval request is level while flag set
`timescale 1ns/1ps
module wit_top (
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	input  wire logic        STANDBY,
	input  wire logic [15:0] BUS_ADDR,
	input  wire logic [15:0] BUS_WDATA,
	input  wire logic        BUS_WR,
	input  wire logic        BUS_WORD,
	input  wire logic        BUS_RD,
	output logic      [7:0]  BUS_RDATA,
	output logic             OVF_IRQ,
	output logic             NMI_REQ,
	output logic             CHIP_RST
);
	import wit_pkg::*;

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0]           cnt_r;
	logic                 ovf_r;
	logic                 mode_r;
	logic                 run_r;
	logic                 act_r;
	logic [WIT_CKS_W-1:0] cks_r;
	logic                 ovf_seen_r;
	logic [WIT_HOLD_W-1:0] hold_r;
	logic                 tick;
	logic                 wr_hit;
	logic                 csr_wr;
	logic                 cnt_wr;
	logic                 overflow;
	logic                 csr_rd;
	logic [7:0]           csr_val;
	logic                 wd_nmi_hit;
	logic                 wd_rst_hit;

	wit_prescaler u_pre (
		.clk   (MCLK),
		.rst_n (rst_n),
		.sel   (cks_r),
		.tick  (tick)
	);

	// ---------------------------------------------------------------
	// bus decode and events
	// ---------------------------------------------------------------
	// byte writes are dropped: the password needs the high byte
	assign wr_hit   = BUS_WR && BUS_WORD && (BUS_ADDR == WIT_CSR_ADDR);
	assign csr_wr   = wr_hit && (BUS_WDATA[15:8] == WIT_PW_CSR);                   // see RULE12
	assign cnt_wr   = wr_hit && (BUS_WDATA[15:8] == WIT_PW_CNT);                   // see RULE12
	// a count cleared by standby is not a wrap, so no overflow then
	assign overflow = run_r && tick && !cnt_wr && !STANDBY && (cnt_r == WIT_CNT_MAX);  // see RULE2
	assign csr_rd   = BUS_RD && (BUS_ADDR == WIT_CSR_ADDR);
	assign csr_val  = {ovf_r, mode_r, run_r, 1'b1, act_r, cks_r};                  // see RULE8

	assign wd_nmi_hit = overflow && mode_r && !act_r;                              // see RULE9
	assign wd_rst_hit = overflow && mode_r && act_r;                               // see RULE9

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= WIT_CNT_RESET;                                                // see RULE3
		end else if (!run_r || STANDBY) begin
			cnt_r <= WIT_CNT_RESET;                                                // see RULE3
		end else if (cnt_wr) begin
			cnt_r <= BUS_WDATA[7:0];           // write wins over a same-cycle tick
		end else if (tick) begin
			cnt_r <= cnt_r + 8'h01;                                                // see RULE1
		end
	end

	// ---------------------------------------------------------------
	// control bits
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= WIT_CSR_RESET[WIT_MODE_BIT];
			run_r  <= WIT_CSR_RESET[WIT_RUN_BIT];
			act_r  <= WIT_CSR_RESET[WIT_ACT_BIT];
		end else if (STANDBY) begin
			mode_r <= 1'b0;                                                        // see RULE4
			run_r  <= 1'b0;                                                        // see RULE4
			act_r  <= 1'b0;                                                        // see RULE4
		end else if (csr_wr) begin
			mode_r <= BUS_WDATA[WIT_MODE_BIT];                                     // see RULE6
			run_r  <= BUS_WDATA[WIT_RUN_BIT];                                      // see RULE7
			act_r  <= BUS_WDATA[WIT_ACT_BIT];                                      // see RULE9
		end
	end

	// select survives standby; change it only while stopped or a count may slip
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cks_r <= WIT_CSR_RESET[WIT_CKS_MSB:0];
		end else if (csr_wr) begin
			cks_r <= BUS_WDATA[WIT_CKS_MSB:0];                                     // see RULE10
		end
	end

	// ---------------------------------------------------------------
	// overflow flag
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ovf_seen_r <= 1'b0;
		end else if (STANDBY || (csr_wr && !BUS_WDATA[WIT_OVF_BIT])) begin
			ovf_seen_r <= 1'b0;
		end else if (csr_rd && ovf_r) begin
			ovf_seen_r <= 1'b1;                                                    // see RULE5
		end
	end

	// set beats clear; writing one is ignored
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ovf_r <= WIT_CSR_RESET[WIT_OVF_BIT];
		end else if (overflow) begin
			ovf_r <= 1'b1;                                                         // see RULE2
		end else if (STANDBY) begin
			ovf_r <= 1'b0;                                                         // see RULE4
		end else if (csr_wr && !BUS_WDATA[WIT_OVF_BIT] && ovf_seen_r) begin
			ovf_r <= 1'b0;                                                         // see RULE5
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	// data stands until the next read; unmapped reads give zero
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			BUS_RDATA <= 8'h00;
		end else if (BUS_RD) begin
			if (BUS_ADDR == WIT_CSR_ADDR) begin
				BUS_RDATA <= csr_val;
			end else if (BUS_ADDR == WIT_CNT_ADDR) begin
				BUS_RDATA <= cnt_r;
			end else begin
				BUS_RDATA <= 8'h00;
			end
		end
	end

	// ---------------------------------------------------------------
	// requests
	// ---------------------------------------------------------------
	// level, so the controller cannot miss it while the flag stands
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			OVF_IRQ <= 1'b0;
		end else begin
			OVF_IRQ <= ovf_r && !mode_r;                                           // see RULE14
		end
	end

	// one-cycle pulse; the controller must latch it
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			NMI_REQ <= 1'b0;
		end else begin
			NMI_REQ <= wd_nmi_hit;                                                 // see RULE6
		end
	end

	// hold counter is not cleared by standby so a pending reset completes
	// a second overflow inside the hold restarts the window
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= '0;
		end else if (wd_rst_hit) begin
			hold_r <= WIT_RST_HOLD_CNT;                                            // see RULE13
		end else if (hold_r != '0) begin
			hold_r <= hold_r - 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			CHIP_RST <= 1'b0;
		end else begin
			CHIP_RST <= wd_rst_hit || (hold_r > 1);                                // see RULE13
		end
	end
endmodule

// >>> tb/wit_host.sv
// wit_host: interrupt controller and chip reset logic seen by the timer
// assumes the timer's request outputs are registered on MCLK
`timescale 1ns/1ps
module wit_host (
	input  wire logic MCLK,
	input  wire logic NMI_REQ,
	input  wire logic CHIP_RST,
	output int        rst_len,
	output int        nmi_gap
);
	int run;
	int since;
	always @(posedge MCLK) begin
		since <= NMI_REQ ? 1 : since + 1;
		if (NMI_REQ) nmi_gap <= since;
		run <= CHIP_RST ? run + 1 : 0;
		if (!CHIP_RST && run != 0) rst_len <= run;
	end
endmodule

// >>> tb/wit_chk.sv
// wit_chk: port-level checks for the watchdog / interval timer
// assumes the bench spaces a write and a read by one idle cycle
`timescale 1ns/1ps
module wit_chk (
	input wire logic        MCLK,
	input wire logic        RST_B,
	input wire logic        STANDBY,
	input wire logic [15:0] BUS_ADDR,
	input wire logic [15:0] BUS_WDATA,
	input wire logic        BUS_WR,
	input wire logic        BUS_WORD,
	input wire logic        BUS_RD,
	input wire logic [7:0]  BUS_RDATA,
	input wire logic        OVF_IRQ,
	input wire logic        NMI_REQ,
	input wire logic        CHIP_RST
);
	import wit_pkg::*;
	int unsigned hold_r;
	// counter, since 518 is too long for a repetition
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) hold_r <= 0;
		else hold_r <= CHIP_RST ? hold_r + 1 : 0;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	chk_nmi_one: assert property (NMI_REQ |=> !NMI_REQ) else $error("nmi request too long");
	chk_rst_len: assert property ($fell(CHIP_RST) |-> hold_r == 518) else $error("chip reset length");
	chk_rst_max: assert property (hold_r <= 518) else $error("chip reset too long");
	chk_bit_one: assert property (BUS_RD && BUS_ADDR == WIT_CSR_ADDR |=> BUS_RDATA[4]) else $error("bit4 low");
	chk_rd_unmap: assert property (BUS_RD && BUS_ADDR != WIT_CSR_ADDR && BUS_ADDR != WIT_CNT_ADDR
		|=> BUS_RDATA == 8'h00) else $error("unmapped read not zero");
	chk_rd_hold: assert property (!BUS_RD |=> $stable(BUS_RDATA)) else $error("read data moved");
	chk_stby_irq: assert property (STANDBY |-> ##2 !OVF_IRQ) else $error("irq kept in standby");
	chk_csr_wr: assert property (BUS_WR && BUS_WORD && BUS_ADDR == WIT_CSR_ADDR && BUS_WDATA[15:8] == WIT_PW_CSR
		&& !STANDBY ##1 !BUS_WR && !STANDBY ##1 BUS_RD && BUS_ADDR == WIT_CSR_ADDR && !STANDBY
		|=> BUS_RDATA[6:0] == {$past(BUS_WDATA[6:5], 3), 1'b1, $past(BUS_WDATA[3:0], 3)})
		else $error("control write not seen");
	cover property ($rose(OVF_IRQ));
	cover property (NMI_REQ);
	cover property ($fell(CHIP_RST));
endmodule
bind wit_top wit_chk i_chk (.MCLK(MCLK), .RST_B(RST_B), .STANDBY(STANDBY), .BUS_ADDR(BUS_ADDR),
	.BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_WORD(BUS_WORD), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
	.OVF_IRQ(OVF_IRQ), .NMI_REQ(NMI_REQ), .CHIP_RST(CHIP_RST));

// >>> tb/watchdog_interval_timer_tb.sv
// watchdog_interval_timer_tb: register, overflow and request tests
// assumes chip reset is observed only, not fed back to RST_B
`timescale 1ns/1ps
module watchdog_interval_timer_tb;
	import wit_pkg::*;
	typedef struct {logic [15:0] d; logic w; logic [15:0] a; logic [7:0] e;} wit_row_t;
	logic MCLK = 0, RST_B = 0, STANDBY = 0, BUS_WR = 0, BUS_WORD = 0, BUS_RD = 0;
	logic [15:0] BUS_ADDR = 16'h0000, BUS_WDATA = 16'h0000;
	logic [7:0] BUS_RDATA;
	logic OVF_IRQ, NMI_REQ, CHIP_RST;
	int failures = 0, checked = 0, rst_len, nmi_gap;
	int dv [4] = '{2, 32, 64, 128};
	wit_row_t rows [6] = '{'{16'ha520, 1, WIT_CSR_ADDR, 8'h30}, '{16'ha5ff, 1, WIT_CSR_ADDR, 8'h7f},
		'{16'ha500, 0, WIT_CSR_ADDR, 8'h7f}, '{16'h1200, 1, WIT_CSR_ADDR, 8'h7f},
		'{16'ha500, 1, 16'hffa0, 8'h00}, '{16'ha500, 1, WIT_CNT_ADDR, 8'h00}};
	wit_top i_dut (.MCLK(MCLK), .RST_B(RST_B), .STANDBY(STANDBY), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
		.BUS_WR(BUS_WR), .BUS_WORD(BUS_WORD), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .OVF_IRQ(OVF_IRQ),
		.NMI_REQ(NMI_REQ), .CHIP_RST(CHIP_RST));
	wit_host i_host (.MCLK(MCLK), .NMI_REQ(NMI_REQ), .CHIP_RST(CHIP_RST), .rst_len(rst_len), .nmi_gap(nmi_gap));
	initial forever #2.5 MCLK = ~MCLK;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] d, input logic w = 1);
		@(posedge MCLK);
		{BUS_WR, BUS_WORD, BUS_ADDR, BUS_WDATA} <= {1'b1, w, WIT_CSR_ADDR, d};
		@(posedge MCLK);
		BUS_WR <= 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge MCLK);
		{BUS_RD, BUS_ADDR} <= {1'b1, a};
		@(posedge MCLK);
		BUS_RD <= 0;
		@(negedge MCLK);
		chk(BUS_RDATA, e);
	endtask
	localparam int SIG_OVF = 0;
	localparam int SIG_NMI = 1;
	localparam int SIG_RST = 2;
	function automatic logic pick(input int which);
		return (which == SIG_OVF) ? OVF_IRQ : (which == SIG_NMI) ? NMI_REQ : CHIP_RST;
	endfunction
	// sampled at the falling edge, where a one-cycle pulse has settled
	task automatic wait_for(input int which, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge MCLK);
			if (pick(which) === 1'b1) break;
		end
		chk(pick(which), 1'b1);
	endtask
	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge MCLK);
		failures++;
		end_sim();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge MCLK);
		RST_B <= 1;
		repeat (3) @(posedge MCLK);
		rd(WIT_CSR_ADDR, 8'h10);
		rd(WIT_CNT_ADDR, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].d, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		wr(16'ha520);
		wr(16'h5afe);
		wait_for(SIG_OVF, 10);
		wr(16'ha520);
		rd(WIT_CSR_ADDR, 8'hb0);
		wr(16'ha520);
		repeat (3) @(negedge MCLK);
		chk(OVF_IRQ, 0);
		for (int c = 0; c < 4; c++) begin
			wr(16'ha500);
			wr({8'ha5, 5'h0c, c[2:0]});
			wr(16'h5aff);
			wait_for(SIG_NMI, 2 * dv[c] + 10);
			wait_for(SIG_NMI, 256 * dv[c] + 10);
			@(negedge MCLK);
			chk(16'(nmi_gap), 16'(256 * dv[c]));
			chk(OVF_IRQ, 0);
		end
		wr(16'ha500);
		wr(16'ha568);
		wr(16'h5afe);
		wait_for(SIG_RST, 20);
		// reset is not fed back, so stop the count before it wraps inside the hold
		wr(16'ha500);
		repeat (530) @(posedge MCLK);
		chk(16'(rst_len), 16'd518);
		wr(16'ha567);
		@(posedge MCLK);
		STANDBY <= 1;
		repeat (3) @(posedge MCLK);
		STANDBY <= 0;
		rd(WIT_CSR_ADDR, 8'h17);
		rd(WIT_CNT_ADDR, 8'h00);
		end_sim();
	end
endmodule
